/* File: timer16_pkg.sv */
// package: register map, field layout and constants of the 16-bit timer core
`default_nettype none
package timer16_pkg;
   // ****************************************************************
   // byte addresses on the 8-bit cpu bus of the timer
   // ****************************************************************
   localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
   localparam logic [3:0] ADDR_CTRL_C     = 4'h2;
   localparam logic [3:0] ADDR_COUNT_L    = 4'h4;
   localparam logic [3:0] ADDR_COUNT_H    = 4'h5;
   localparam logic [3:0] ADDR_CAPTURE_L  = 4'h6;
   localparam logic [3:0] ADDR_CAPTURE_H  = 4'h7;
   localparam logic [3:0] ADDR_CMP_A_L    = 4'h8;
   localparam logic [3:0] ADDR_CMP_A_H    = 4'h9;
   localparam logic [3:0] ADDR_CMP_B_L    = 4'ha;
   localparam logic [3:0] ADDR_CMP_B_H    = 4'hb;
   localparam logic [3:0] ADDR_CMP_C_L    = 4'hc;
   localparam logic [3:0] ADDR_CMP_C_H    = 4'hd;
   localparam logic [3:0] ADDR_FLAG       = 4'he;
   localparam logic [3:0] ADDR_MASK       = 4'hf;
   // ****************************************************************
   // fields
   // ****************************************************************
   localparam int CS_LSB     = 0;   // control b clock select [2:0]
   localparam int CS_W       = 3;
   localparam int NC_BIT     = 7;   // control b noise canceler enable
   localparam int CES_BIT    = 6;   // control b capture edge (1 = rising)
   localparam int TOPSEL_LSB = 0;   // control a top select [2:0]
   localparam int FLAG_OVF   = 0;
   localparam int FLAG_CMP_A = 1;   // a,b,c follow at 1,2,3
   localparam int FLAG_CAP   = 5;
   localparam int NC_SAMPLES = 4;
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [2:0] TOP_MAX     = 3'h0;
   localparam logic [2:0] TOP_8BIT    = 3'h1;
   localparam logic [2:0] TOP_9BIT    = 3'h2;
   localparam logic [2:0] TOP_10BIT   = 3'h3;
   localparam logic [2:0] TOP_CMP_A   = 3'h4;
   localparam logic [2:0] TOP_CAPTURE = 3'h5;
   localparam logic [15:0] VAL_BOTTOM = 16'h0000;
   localparam logic [15:0] VAL_MAX    = 16'hffff;
   localparam logic [15:0] VAL_TOP8   = 16'h00ff;
   localparam logic [15:0] VAL_TOP9   = 16'h01ff;
   localparam logic [15:0] VAL_TOP10  = 16'h03ff;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   // prescaler taps in core_clk cycles for selects 1..5
   localparam int PRESC_1 = 1;
   localparam int PRESC_2 = 8;
   localparam int PRESC_3 = 64;
   localparam int PRESC_4 = 256;
   localparam int PRESC_5 = 1024;
endpackage : timer16_pkg
`default_nettype wire

/* File: timer16_bus_if.sv */
// interface: 8-bit cpu i/o bus between the cpu end and the timer
`default_nettype none
interface timer16_bus_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr;
   logic       rd;
   logic       power_cut;
   modport cpu   (output addr, output wdata, output wr, output rd, output power_cut,
                  input rdata);
   modport timer (input addr, input wdata, input wr, input rd, input power_cut,
                  output rdata);
endinterface : timer16_bus_if
`default_nettype wire

/* File: timer16_core.sv */
// timer end: 16-bit timer core with shared high-byte holding register
// Notes on behaviour
// - software clears power cut before timer runs
// - count, compares, capture 16-bit; controls 8-bit
// - every request flagged, each gated by mask
// - tick from prescaler or external pin edge
// - compare values compared with counter on each tick
// - compare match sets its match flag
// - capture edge copies counter, optional filter
// - compare a as top: no pwm, buffered
// - bottom is counter equal zero
// - max is counter all ones
// - top fixed, compare a or capture
// - one shared 8-bit holding register
// - low write loads holding and low together
// - low read copies high into holding
// - compare reads bypass holding register
// - write high first; read low first
// - main code blocks interrupts around access
// - holding register reusable for several writes
// - three-bit clock select in control b
// - select zero stops counter, cpu access stays
// - cpu write beats counter update
`default_nettype none
module timer16_core
   import timer16_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   rst_n,
   timer16_bus_if.timer bus,
   input  wire logic   external_count_pin,
   input  wire logic   capture_input_pin,
   input  wire logic   comparator_out,
   input  wire logic   capture_from_comparator,
   output logic [2:0]  compare_output_pins,
   output logic        irq
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0]  timer_control_a, timer_control_b, timer_control_c;
   logic [15:0] timer_count, capture_value;
   logic [15:0] compare_value [3];
   logic [15:0] compare_buf   [3];
   logic [7:0]  holding;
   logic [7:0]  timer_flag_reg, timer_mask_reg;
   logic        enabled;
   assign enabled = !bus.power_cut;

   // ****************************************************************
   // pin synchronisers and tick
   // ****************************************************************
   logic [1:0] ext_sync, icp_sync, aco_sync;
   logic       ext_prev;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sync <= 2'h0;
         icp_sync <= 2'h0;
         aco_sync <= 2'h0;
         ext_prev <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[0], external_count_pin};
         icp_sync <= {icp_sync[0], capture_input_pin};
         aco_sync <= {aco_sync[0], comparator_out};
         ext_prev <= ext_sync[1];
      end
   end

   logic [9:0] presc;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         presc <= 10'h000;
      else if (enabled)
         presc <= presc + 10'h001;
   end

   logic [2:0] cs;
   logic       tick;
   assign cs = timer_control_b[CS_LSB +: CS_W];
   always_comb begin
      case (cs)
         CS_STOP:     tick = 1'b0;
         3'h1:        tick = 1'b1;
         3'h2:        tick = (presc[2:0] == 3'(PRESC_2 - 1));
         3'h3:        tick = (presc[5:0] == 6'(PRESC_3 - 1));
         3'h4:        tick = (presc[7:0] == 8'(PRESC_4 - 1));
         3'h5:        tick = (presc == 10'(PRESC_5 - 1));
         CS_EXT_FALL: tick = ext_prev && !ext_sync[1];
         CS_EXT_RISE: tick = !ext_prev && ext_sync[1];
         default:     tick = 1'b0;
      endcase
   end

   // ****************************************************************
   // top, bottom, max and compare
   // ****************************************************************
   logic [15:0] top_value;
   logic        at_bottom, at_max, at_top;
   always_comb begin
      case (timer_control_a[TOPSEL_LSB +: 3])
         TOP_8BIT:    top_value = VAL_TOP8;
         TOP_9BIT:    top_value = VAL_TOP9;
         TOP_10BIT:   top_value = VAL_TOP10;
         TOP_CMP_A:   top_value = compare_value[0];
         TOP_CAPTURE: top_value = capture_value;
         default:     top_value = VAL_MAX;
      endcase
   end
   assign at_bottom = (timer_count == VAL_BOTTOM);
   assign at_max    = (timer_count == VAL_MAX);
   assign at_top    = (timer_count == top_value);

   logic [2:0] match;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_cmp
         assign match[g] = tick && (timer_count == compare_value[g]);
      end
   endgenerate

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic wr, rd;
   assign wr = bus.wr && enabled;
   assign rd = bus.rd && enabled;
   logic       top_is_capture, buffered;
   assign top_is_capture = (timer_control_a[TOPSEL_LSB +: 3] == TOP_CAPTURE);
   // compare values are double buffered only while compare a sets the top
   assign buffered = (timer_control_a[TOPSEL_LSB +: 3] == TOP_CMP_A);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_a <= RESET_BYTE;
         timer_control_b <= RESET_BYTE;
         timer_control_c <= RESET_BYTE;
         timer_mask_reg  <= RESET_BYTE;
      end else if (wr) begin
         case (bus.addr)
            ADDR_CTRL_A: timer_control_a <= bus.wdata;
            ADDR_CTRL_B: timer_control_b <= bus.wdata;
            ADDR_CTRL_C: timer_control_c <= bus.wdata;
            ADDR_MASK:   timer_mask_reg  <= bus.wdata;
            default: ;
         endcase
      end
   end

   // holding register: high writes load it, count and capture low reads refill it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         holding <= RESET_BYTE;
      else if (wr && (bus.addr == ADDR_COUNT_H || bus.addr == ADDR_CAPTURE_H ||
                      bus.addr == ADDR_CMP_A_H || bus.addr == ADDR_CMP_B_H ||
                      bus.addr == ADDR_CMP_C_H))
         holding <= bus.wdata;
      else if (rd && bus.addr == ADDR_COUNT_L)
         holding <= timer_count[15:8];
      else if (rd && bus.addr == ADDR_CAPTURE_L)
         holding <= capture_value[15:8];
   end

   // ****************************************************************
   // counter
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         timer_count <= 16'h0000;
      else if (wr && bus.addr == ADDR_COUNT_L)
         timer_count <= {holding, bus.wdata};
      else if (tick && enabled)
         timer_count <= (at_top || at_max) ? VAL_BOTTOM : timer_count + 16'h0001;
   end

   // ****************************************************************
   // compare values with top-time update when buffered
   // ****************************************************************
   generate
      for (g = 0; g < 3; g++) begin : g_cval
         logic wr_low;
         assign wr_low = wr && (bus.addr == 4'(ADDR_CMP_A_L + 2 * g));
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               compare_buf[g]   <= 16'h0000;
               compare_value[g] <= 16'h0000;
            end else begin
               if (wr_low)
                  compare_buf[g] <= {holding, bus.wdata};
               if (wr_low && !buffered)
                  compare_value[g] <= {holding, bus.wdata};
               else if (buffered && tick && at_top)
                  compare_value[g] <= compare_buf[g];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // capture with optional four-sample filter
   // ****************************************************************
   logic                  cap_raw, cap_filt, cap_prev, cap_event;
   logic [NC_SAMPLES-1:0] nc_hist;
   assign cap_raw = capture_from_comparator ? aco_sync[1] : icp_sync[1];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nc_hist  <= '0;
         cap_filt <= 1'b0;
         cap_prev <= 1'b0;
      end else begin
         nc_hist <= {nc_hist[NC_SAMPLES-2:0], cap_raw};
         // filter adds four cycles but rejects short spikes
         if (!timer_control_b[NC_BIT])
            cap_filt <= cap_raw;
         else if (&nc_hist)
            cap_filt <= 1'b1;
         else if (~|nc_hist)
            cap_filt <= 1'b0;
         cap_prev <= cap_filt;
      end
   end
   // no capture while the capture value defines top
   assign cap_event = !top_is_capture && enabled &&
                      (timer_control_b[CES_BIT] ? (cap_filt && !cap_prev)
                                                : (!cap_filt && cap_prev));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         capture_value <= 16'h0000;
      else if (cap_event)
         capture_value <= timer_count;
      else if (wr && top_is_capture && bus.addr == ADDR_CAPTURE_L)
         capture_value <= {holding, bus.wdata};
   end

   // ****************************************************************
   // flags: set wins over write-one-to-clear
   // ****************************************************************
   logic [7:0] set_bits, clr_bits;
   always_comb begin
      set_bits = 8'h00;
      set_bits[FLAG_OVF]            = tick && enabled && (at_top || at_max);
      set_bits[FLAG_CMP_A +: 3]     = enabled ? match : 3'h0;
      set_bits[FLAG_CAP]            = cap_event;
      clr_bits = (wr && bus.addr == ADDR_FLAG) ? bus.wdata : 8'h00;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         timer_flag_reg <= RESET_BYTE;
      else
         timer_flag_reg <= (timer_flag_reg & ~clr_bits) | set_bits;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(timer_flag_reg & timer_mask_reg);
   end

   // compare a drives no pwm output when it sets the top
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         compare_output_pins <= 3'h0;
      else if (match[0] && !buffered)
         compare_output_pins[0] <= !compare_output_pins[0];
      else if (match[1])
         compare_output_pins[1] <= !compare_output_pins[1];
      else if (match[2])
         compare_output_pins[2] <= !compare_output_pins[2];
   end

   // ****************************************************************
   // read data, registered
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         bus.rdata <= 8'h00;
      else if (rd) begin
         case (bus.addr)
            ADDR_CTRL_A:    bus.rdata <= timer_control_a;
            ADDR_CTRL_B:    bus.rdata <= timer_control_b;
            ADDR_CTRL_C:    bus.rdata <= timer_control_c;
            ADDR_COUNT_L:   bus.rdata <= timer_count[7:0];
            ADDR_COUNT_H:   bus.rdata <= holding;
            ADDR_CAPTURE_L: bus.rdata <= capture_value[7:0];
            ADDR_CAPTURE_H: bus.rdata <= holding;
            ADDR_CMP_A_L:   bus.rdata <= compare_buf[0][7:0];
            ADDR_CMP_A_H:   bus.rdata <= compare_buf[0][15:8];
            ADDR_CMP_B_L:   bus.rdata <= compare_buf[1][7:0];
            ADDR_CMP_B_H:   bus.rdata <= compare_buf[1][15:8];
            ADDR_CMP_C_L:   bus.rdata <= compare_buf[2][7:0];
            ADDR_CMP_C_H:   bus.rdata <= compare_buf[2][15:8];
            ADDR_FLAG:      bus.rdata <= timer_flag_reg;
            ADDR_MASK:      bus.rdata <= timer_mask_reg;
            default:        bus.rdata <= 8'h00;
         endcase
      end
   end
endmodule : timer16_core
`default_nettype wire

/* File: timer16_cpu.sv */
// cpu end: wishbone slave that runs ordered 16-bit accesses on the timer bus
`default_nettype none
module timer16_cpu
   import timer16_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   rst_n,
   timer16_bus_if.cpu  bus,
   input  wire logic   cyc_i,
   input  wire logic   stb_i,
   input  wire logic   we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic        ack_o
);
   // ****************************************************************
   // word at adr_i*4 = timer byte address; 16-bit regs use low half
   // power control word selected by sel_i[3], whatever adr_i holds
   // ****************************************************************
   typedef enum {IDLE, HIGH, LOW, WAIT, DONE} state_type;
   state_type  state;
   logic       wide, is_power;
   logic [7:0] low_byte;
   assign wide = (adr_i >= ADDR_COUNT_L) && (adr_i <= ADDR_CMP_C_L) && !adr_i[0];
   assign is_power = sel_i[3];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= IDLE;
         bus.addr      <= 4'h0;
         bus.wdata     <= 8'h00;
         bus.wr        <= 1'b0;
         bus.rd        <= 1'b0;
         bus.power_cut <= 1'b1;
         dat_o         <= 32'h0;
         ack_o         <= 1'b0;
         low_byte      <= 8'h00;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         ack_o  <= 1'b0;
         case (state)
            IDLE: if (cyc_i && stb_i && !ack_o) begin
               if (is_power) begin
                  if (we_i)
                     bus.power_cut <= dat_i[0];
                  dat_o <= {31'h0, bus.power_cut};
                  state <= DONE;
               end else if (wide && we_i) begin
                  bus.addr  <= adr_i + 4'h1;
                  bus.wdata <= dat_i[15:8];
                  bus.wr    <= 1'b1;
                  state     <= LOW;
               end else begin
                  bus.addr  <= adr_i;
                  bus.wdata <= dat_i[7:0];
                  bus.wr    <= we_i;
                  bus.rd    <= !we_i;
                  state     <= wide ? HIGH : WAIT;
               end
            end
            LOW: begin
               bus.addr  <= adr_i; // low byte second
               bus.wdata <= dat_i[7:0];
               bus.wr    <= 1'b1;
               state     <= WAIT;
            end
            HIGH: begin
               bus.addr <= adr_i + 4'h1; // high byte after low
               bus.rd   <= 1'b1;
               state    <= WAIT;
            end
            WAIT: begin
               // whole pair runs back to back, so no other access splits it
               low_byte <= bus.rdata;
               if (wide && !we_i && bus.addr[0])
                  state <= DONE;
               else begin
                  dat_o <= {24'h0, bus.rdata};
                  state <= DONE;
               end
            end
            DONE: begin
               // single byte and 16-bit reads land here, one cycle after the timer registered their last byte
               if (!we_i && !is_power)
                  dat_o <= wide ? {16'h0, bus.rdata, low_byte} : {24'h0, bus.rdata};
               ack_o <= 1'b1;
               state <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end
endmodule : timer16_cpu
`default_nettype wire

/* File: timer16_checker.sv */
// checker: ordering and data relations on the bus between the cpu end and the timer
`default_nettype none
module timer16_checker
   import timer16_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       power_cut,
   input  wire logic       irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // images of what the cpu wrote
   // ****************************************************************
   logic [7:0]  hold;
   logic [7:0]  mask_img;
   logic [3:0]  addr_q;
   logic [15:0] cmp_img [3];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold     <= 8'h00;
         mask_img <= 8'h00;
         addr_q   <= 4'h0;
         cmp_img  <= '{default: 16'h0000};
      end else begin
         addr_q <= addr;
         // frozen timer ignores the bus, so the images must too
         if (wr && !power_cut) begin
            if (addr[0] && addr >= ADDR_COUNT_H && addr <= ADDR_CMP_C_H) hold <= wdata;
            if (addr == ADDR_MASK) mask_img <= wdata;
            if (!addr[0] && addr >= ADDR_CMP_A_L && addr <= ADDR_CMP_C_L)
               cmp_img[addr[2:1]] <= {hold, wdata};
         end
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence lo_write;
      wr && !addr[0] && addr >= ADDR_COUNT_L && addr <= ADDR_CMP_C_L;
   endsequence
   sequence lo_read;
      rd && !addr[0] && addr >= ADDR_COUNT_L && addr <= ADDR_CMP_C_L;
   endsequence
   a_power_at_release: assert property ($rose(rst_n) |-> power_cut)
      else $error("timer not frozen after reset");
   a_frozen_rdata_still: assert property (power_cut |=> $stable(rdata))
      else $error("read data moved while frozen");
   a_no_rd_wr_clash: assert property (!(wr && rd))
      else $error("read and write in one cycle");
   a_high_write_first: assert property (lo_write |-> $past(wr) && addr_q == (addr | 4'h1))
      else $error("low byte written without high byte just before");
   a_low_read_first: assert property (lo_read |=> rd && addr == (addr_q | 4'h1))
      else $error("low byte read not followed by high byte read");
   a_rdata_holds: assert property (!rd |=> $stable(rdata))
      else $error("read data changed without a read");
   a_cmp_read_direct: assert property (rd && !power_cut && addr >= ADDR_CMP_A_L
      && addr <= ADDR_CMP_C_H |=> rdata == (addr_q[0] ? cmp_img[addr_q[2:1]][15:8]
      : cmp_img[addr_q[2:1]][7:0])) else $error("compare byte differs from written value");
   a_mask_gates_irq: assert property ($past(mask_img) == 8'h00 |-> !irq)
      else $error("request raised with every enable off");
endmodule : timer16_checker
`default_nettype wire

/* File: sixteen_bit_timer_core_access_tb.sv */
// testbench: wishbone sequences against the cpu end and the timer core together
`default_nettype none
module sixteen_bit_timer_core_access_tb
   import timer16_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 1'b0;
   logic        rst_n, cyc, stb, we, ext_pin, cap_pin, cmp_out, cap_src, irq, ack_o;
   logic [3:0]  adr, sel;
   logic [31:0] dat, dat_o, pw;
   logic [2:0]  pins;
   logic [15:0] q;
   int          err_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   localparam logic [3:0] ZADDR [9] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_COUNT_L,
      ADDR_CAPTURE_L, ADDR_CMP_A_L, ADDR_CMP_B_L, ADDR_CMP_C_L, ADDR_MASK};
   localparam logic [15:0] CMPV [3] = '{16'h0020, 16'h0140, 16'h0260};
   localparam logic [2:0]  TOPS [4] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_CMP_A};
   localparam logic [15:0] LIMS [4] = '{VAL_TOP8, VAL_TOP9, VAL_TOP10, 16'h0020};
   // compare b and c only match when the top reaches them
   localparam logic [15:0] FLGS [4] = '{16'h0003, 16'h0007, 16'h000f, 16'h0003};
   localparam logic [2:0]  CSS [3] = '{CS_STOP, CS_EXT_FALL, CS_EXT_RISE};
   always #2.5 core_clk = ~core_clk;
   timer16_bus_if bus_if ();
   timer16_cpu timer16_cpu_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
      .dat_o(dat_o), .ack_o(ack_o));
   timer16_core timer16_core_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
      .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
      .capture_from_comparator(cap_src), .compare_output_pins(pins), .irq(irq));
   timer16_checker timer16_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .wr(bus_if.wr),
      .rd(bus_if.rd), .power_cut(bus_if.power_cut), .irq(irq));
   // ****************************************************************
   // bus cycles and comparison
   // ****************************************************************
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      // no fixed latency assumed; the watchdog ends a hang
      do @(posedge core_clk); while (ack_o !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [31:0] r;
      wb(1'b1, a, 4'h1, {16'h0000, d}, r);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      logic [31:0] r;
      wb(1'b0, a, 4'h1, 32'h0, r);
      v = r[15:0];
   endtask : rd
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         close_out();
      end
   end
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      {rst_n, cyc, stb, we, ext_pin, cap_pin, cmp_out, cap_src} = 8'h00;
      {adr, sel, dat} = 40'h0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(ADDR_COUNT_L, 16'h4321);
      wb(1'b1, 4'h0, 4'h8, 32'h0, pw);
      foreach (ZADDR[i]) begin
         rd(ZADDR[i], q);
         chk(q, 16'h0000);
      end
      $display("test reset_and_power done");
      wr(ADDR_COUNT_L, 16'h1234);
      repeat (20) @(posedge core_clk);
      rd(ADDR_COUNT_L, q);
      chk(q, 16'h1234);
      rd(ADDR_COUNT_H, q);
      chk(q, 16'h0012);
      rd(ADDR_CAPTURE_L, q);
      rd(ADDR_COUNT_H, q);
      chk(q, 16'h0000);
      foreach (CMPV[i]) wr(ADDR_CMP_A_L + 4'(2 * i), CMPV[i]);
      foreach (CMPV[i]) begin
         rd(ADDR_CMP_A_L + 4'(2 * i), q);
         chk(q, CMPV[i]);
         rd(ADDR_CMP_A_H + 4'(2 * i), q);
         chk(q, {8'h00, CMPV[i][15:8]});
      end
      $display("test byte_access done");
      wr(ADDR_MASK, 16'h0002);
      foreach (TOPS[i]) begin
         wr(ADDR_COUNT_L, 16'h0000);
         wr(ADDR_FLAG, 16'h00ff);
         wr(ADDR_CTRL_A, {13'h0, TOPS[i]});
         wr(ADDR_CTRL_B, 16'h0001);
         repeat (1500) @(posedge core_clk);
         wr(ADDR_CTRL_B, 16'h0000);
         rd(ADDR_COUNT_L, q);
         chk({15'h0, q <= LIMS[i]}, 16'h0001);
         rd(ADDR_FLAG, q);
         chk(q & 16'h000f, FLGS[i]);
         chk({15'h0, irq}, 16'h0001);
      end
      wr(ADDR_MASK, 16'h0000);
      repeat (3) @(posedge core_clk);
      chk({15'h0, irq}, 16'h0000);
      wr(ADDR_CTRL_A, 16'h0000);
      $display("test count_top_flags done");
      foreach (CSS[i]) begin
         wr(ADDR_COUNT_L, 16'h0000);
         wr(ADDR_CTRL_B, {13'h0, CSS[i]});
         repeat (5) begin
            ext_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            ext_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
         end
         wr(ADDR_CTRL_B, 16'h0000);
         rd(ADDR_COUNT_L, q);
         chk(q, (CSS[i] == CS_STOP) ? 16'h0000 : 16'h0005);
      end
      $display("test clock_source done");
      for (int k = 0; k < 2; k++) begin
         cap_src <= k[0];
         wr(ADDR_COUNT_L, 16'h0abc + 16'(k));
         wr(ADDR_CTRL_B, k ? 16'h00c0 : 16'h0040);
         wr(ADDR_FLAG, 16'h00ff);
         if (k) cmp_out <= 1'b1;
         else cap_pin <= 1'b1;
         repeat (12) @(posedge core_clk);
         rd(ADDR_CAPTURE_L, q);
         chk(q, 16'h0abc + 16'(k));
         rd(ADDR_FLAG, q);
         chk(q & 16'h0020, 16'h0020);
         cap_pin <= 1'b0;
      end
      $display("test capture done");
      close_out();
   end
endmodule : sixteen_bit_timer_core_access_tb
`default_nettype wire
